// >>> design/sysbus_agent_end.sv
`timescale 1ns/1ps
`default_nettype none
module sysbus_agent_end
  import sysbus_pkg::*;
(
  // link domain only (agent logic lives on the bus clock)
  input  wire logic              link_clk_i,
  input  wire logic              link_resetn_i,
  // user side
  input  wire logic              send_req_i,
  input  wire logic [DATA_W-1:0] send_data_i,
  input  wire logic              send_last_i,
  input  wire logic              out_of_order_completion_n_i,
  output logic                   send_ack_o,
  output logic                   recv_valid_o,
  output logic [DATA_W-1:0]      recv_data_o,
  sysbus_if.agent                bus
);
  logic owning;

  // take bus only when the other owner has released busy
  // released busy alone tells the agent the data lines are free
  wire can_start = !owning && send_req_i && bus.data_bus_busy_n;
  wire go        = can_start || (owning && send_req_i);
  assign send_ack_o = go;

  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) owning <= 1'b0;
    else if (go)        owning <= !send_last_i;
  end

  // data, flag and strobes registered; idle clocks leave valid high
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      bus.agt_busy_o  <= 1'b1;
      bus.agt_valid_o <= 1'b1;
      bus.agt_oe_n    <= 1'b1;
      bus.agt_data_o  <= '1;
      bus.agt_flag_o  <= '1;
      bus.agt_stbn_o  <= '1;
      bus.agt_stbp_o  <= '1;
      bus.agt_out_of_order_completion_n_o <= 1'b1;
    end else begin
      bus.agt_out_of_order_completion_n_o <= !out_of_order_completion_n_i;
      bus.agt_busy_o  <= !(go || owning);
      bus.agt_oe_n    <= !go;
      bus.agt_valid_o <= !go;
      bus.agt_stbn_o  <= go ? '0 : '1;
      bus.agt_stbp_o  <= '1;
      bus.agt_flag_o  <= '1;
      bus.agt_data_o  <= ~send_data_i;
    end
  end

  // data loaded every clock, valid raised only in valid clocks; undo group inversion
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      recv_valid_o <= 1'b0;
      recv_data_o  <= '0;
    end else begin
      recv_valid_o <= !bus.data_valid_n && bus.agt_oe_n;
      for (int g = 0; g < GROUPS; g++)
        recv_data_o[g*GROUP_W +: GROUP_W] <= bus.group_invert_flag_n[g] ?
          ~bus.data_n[g*GROUP_W +: GROUP_W] : bus.data_n[g*GROUP_W +: GROUP_W];
    end
  end
endmodule : sysbus_agent_end
`default_nettype wire

// >>> design/sysbus_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module sysbus_cpu_end
  import sysbus_pkg::*;
(
  // core domain
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // send request: four sub-phase words, held until taken
  input  wire logic              send_req_i,
  input  wire logic [BEAT_W-1:0] send_data_i,
  input  wire logic              send_last_i,
  output logic                   send_ack_o,
  // receive side
  output logic                   recv_valid_o,
  output logic [BEAT_W-1:0]      recv_data_o,
  output logic                   out_of_order_completion_n_seen_o,
  // link domain
  input  wire logic              link_clk_i,
  input  wire logic              link_resetn_i,
  sysbus_if.cpu                  bus
);
  // ---------------- core -> link handshake ----------------
  logic              req_tgl;
  logic              ack_tgl_l;
  logic [2:0]        ack_sync;
  logic [BEAT_W-1:0] hold_data;
  logic              hold_last;
  logic              pending;

  // capture one beat, raise toggle; next beat waits for the link ack
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      req_tgl   <= 1'b0;
      pending   <= 1'b0;
      hold_data <= '0;
      hold_last <= 1'b0;
    end else if (!pending && send_req_i) begin
      req_tgl   <= ~req_tgl;
      pending   <= 1'b1;
      hold_data <= send_data_i;
      hold_last <= send_last_i;
    end else if (pending && ack_sync[1] == ack_sync[2] && ack_sync[2] == req_tgl) begin
      pending <= 1'b0;
    end
  end
  assign send_ack_o = !pending && send_req_i;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) ack_sync <= '0;
    else           ack_sync <= {ack_sync[1:0], ack_tgl_l};
  end

  // ---------------- link-side driver ----------------
  logic [2:0]        req_sync;
  logic              req_seen;
  drv_state_t        state;
  logic              beat_fresh;
  logic              beat_last;
  logic [BEAT_W-1:0] beat_data;

  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) req_sync <= '0;
    else                req_sync <= {req_sync[1:0], req_tgl};
  end
  wire new_beat = (req_sync[1] == req_sync[2]) && (req_sync[2] != req_seen);

  // toggle crossing: data held stable in core domain until acked
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      req_seen   <= 1'b0;
      ack_tgl_l  <= 1'b0;
      beat_fresh <= 1'b0;
      beat_last  <= 1'b0;
      beat_data  <= '0;
    end else begin
      if (state == DRV_BUSY) beat_fresh <= 1'b0;
      // a beat is taken only once the previous one has been put on the bus,
      // so a slow busy release can never overwrite an unsent beat
      if (new_beat && !beat_fresh) begin
        req_seen   <= req_sync[2];
        ack_tgl_l  <= req_sync[2];
        beat_fresh <= 1'b1;
        beat_last  <= hold_last;
        beat_data  <= hold_data;
      end
    end
  end

  // ownership: wait for foreign busy release before driving
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) state <= DRV_IDLE;
    else begin
      case (state)
        DRV_IDLE: if (beat_fresh) state <= DRV_WAIT;
        DRV_WAIT: if (bus.data_bus_busy_n) state <= DRV_BUSY;
        DRV_BUSY: if (beat_fresh && beat_last) state <= DRV_IDLE;
        default:  state <= DRV_IDLE;
      endcase
    end
  end

  // inversion per group of the first sub-phase word only; low-active bus, so bit 0 = driven low
  function automatic logic [DATA_W+GROUPS-1:0] encode(input logic [DATA_W-1:0] w);
    logic [DATA_W-1:0] d;
    logic [GROUPS-1:0] f;
    int                zeros;
    d = ~w;
    f = '1;
    for (int g = 0; g < GROUPS; g++) begin
      zeros = 0;
      for (int b = 0; b < GROUP_W; b++) zeros += int'(!d[g*GROUP_W+b]);
      if (zeros > HALF_GROUP) begin
        d[g*GROUP_W +: GROUP_W] = ~d[g*GROUP_W +: GROUP_W];
        f[g] = 1'b0;
      end
    end
    return {f, d};
  endfunction

  // drive outputs; busy covers every clock spent owning, last beat included
  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      bus.cpu_busy_o  <= 1'b1;
      bus.cpu_valid_o <= 1'b1;
      bus.cpu_oe_n    <= 1'b1;
      bus.cpu_data_o  <= '1;
      bus.cpu_flag_o  <= '1;
      bus.cpu_stbn_o  <= '1;
      bus.cpu_stbp_o  <= '1;
    end else begin
      bus.cpu_busy_o <= !(state == DRV_BUSY);
      bus.cpu_oe_n   <= !(state == DRV_BUSY);
      bus.cpu_valid_o <= !(state == DRV_BUSY && beat_fresh);
      if (state == DRV_BUSY && beat_fresh) begin
        {bus.cpu_flag_o, bus.cpu_data_o} <= encode(beat_data[DATA_W-1:0]);
        bus.cpu_stbn_o <= '0;
        bus.cpu_stbp_o <= '1;
      end else begin
        bus.cpu_stbn_o <= '1;
        bus.cpu_stbp_o <= '1;
      end
    end
  end

  // ---------------- receive ----------------
  logic [BEAT_W-1:0] rx_word;
  logic              rx_tgl;
  logic              out_of_order_completion_n_l;
  logic [2:0]        rx_sync;
  logic [2:0]        out_of_order_completion_n_sync;

  // decode: active-low lines, inverted group when its flag is low
  function automatic logic [DATA_W-1:0] decode(input logic [DATA_W-1:0] n,
                                               input logic [GROUPS-1:0] f);
    logic [DATA_W-1:0] d;
    d = ~n;
    for (int g = 0; g < GROUPS; g++)
      if (!f[g]) d[g*GROUP_W +: GROUP_W] = ~d[g*GROUP_W +: GROUP_W];
    return d;
  endfunction

  always_ff @(posedge link_clk_i) begin
    if (!link_resetn_i) begin
      rx_word <= '0;
      rx_tgl  <= 1'b0;
      out_of_order_completion_n_l <= 1'b0;
    end else begin
      out_of_order_completion_n_l <= !bus.out_of_order_completion_n;
      if (!bus.data_valid_n && bus.cpu_oe_n) begin
        rx_word <= {SUBPHASES{decode(bus.data_n, bus.group_invert_flag_n)}};
        rx_tgl  <= ~rx_tgl;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_sync    <= '0;
      out_of_order_completion_n_sync <= '0;
    end else begin
      rx_sync    <= {rx_sync[1:0], rx_tgl};
      out_of_order_completion_n_sync <= {out_of_order_completion_n_sync[1:0], out_of_order_completion_n_l};
    end
  end

  logic rx_seen;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rx_seen      <= 1'b0;
      recv_valid_o <= 1'b0;
      recv_data_o  <= '0;
      out_of_order_completion_n_seen_o <= 1'b0;
    end else begin
      recv_valid_o <= 1'b0;
      if (rx_sync[1] == rx_sync[2] && rx_sync[2] != rx_seen) begin
        rx_seen      <= rx_sync[2];
        recv_valid_o <= 1'b1;
        recv_data_o  <= rx_word;
      end
      if (out_of_order_completion_n_sync[1] == out_of_order_completion_n_sync[2]) out_of_order_completion_n_seen_o <= out_of_order_completion_n_sync[2];
    end
  end
endmodule : sysbus_cpu_end
`default_nettype wire

// >>> design/sysbus_if.sv
`timescale 1ns/1ps
`default_nettype none
// shared data-phase wires; every signal is active low on the bus
interface sysbus_if (
  input wire logic link_clk
);
  import sysbus_pkg::*;
  // resolved bus levels (wired-or of low-active drivers)
  logic [DATA_W-1:0]  data_n;
  logic [GROUPS-1:0]  group_invert_flag_n;
  logic [GROUPS-1:0]  data_strobe_neg_n;
  logic [GROUPS-1:0]  data_strobe_pos_n;
  logic               data_bus_busy_n;
  logic               data_valid_n;
  logic               out_of_order_completion_n;
  // processor-side drives; enables low while driving
  logic [DATA_W-1:0]  cpu_data_o;
  logic [GROUPS-1:0]  cpu_flag_o;
  logic [GROUPS-1:0]  cpu_stbn_o;
  logic [GROUPS-1:0]  cpu_stbp_o;
  logic               cpu_busy_o;
  logic               cpu_valid_o;
  logic               cpu_oe_n;
  // agent-side drives
  logic [DATA_W-1:0]  agt_data_o;
  logic [GROUPS-1:0]  agt_flag_o;
  logic [GROUPS-1:0]  agt_stbn_o;
  logic [GROUPS-1:0]  agt_stbp_o;
  logic               agt_busy_o;
  logic               agt_valid_o;
  logic               agt_out_of_order_completion_n_o;
  logic               agt_oe_n;

  // resolution: a driven low wins, an undriven line floats high
  assign data_n  = (cpu_oe_n ? '1 : cpu_data_o) & (agt_oe_n ? '1 : agt_data_o);
  assign group_invert_flag_n = (cpu_oe_n ? '1 : cpu_flag_o) & (agt_oe_n ? '1 : agt_flag_o);
  assign data_strobe_neg_n = (cpu_oe_n ? '1 : cpu_stbn_o) & (agt_oe_n ? '1 : agt_stbn_o);
  assign data_strobe_pos_n = (cpu_oe_n ? '1 : cpu_stbp_o) & (agt_oe_n ? '1 : agt_stbp_o);
  assign data_bus_busy_n = cpu_busy_o & agt_busy_o;
  assign data_valid_n    = (cpu_oe_n | cpu_valid_o) & (agt_oe_n | agt_valid_o);
  assign out_of_order_completion_n = agt_out_of_order_completion_n_o;

  modport cpu (
    input  data_n, group_invert_flag_n, data_strobe_neg_n, data_strobe_pos_n,
    input  data_bus_busy_n, data_valid_n, out_of_order_completion_n,
    output cpu_data_o, cpu_flag_o, cpu_stbn_o, cpu_stbp_o, cpu_busy_o,
    output cpu_valid_o, cpu_oe_n
  );
  modport agent (
    input  data_n, group_invert_flag_n, data_strobe_neg_n, data_strobe_pos_n,
    input  data_bus_busy_n, data_valid_n,
    output agt_data_o, agt_flag_o, agt_stbn_o, agt_stbp_o, agt_busy_o,
    output agt_valid_o, agt_out_of_order_completion_n_o, agt_oe_n
  );
endinterface : sysbus_if
`default_nettype wire

// >>> design/sysbus_pkg.sv
package sysbus_pkg;
  localparam int DATA_W     = 64;
  localparam int GROUP_W    = 16;
  localparam int GROUPS     = 4;
  localparam int SUBPHASES  = 4;
  localparam int SUB_IDX_W  = 2;
  localparam int HALF_GROUP = 8;
  localparam int BEAT_W     = DATA_W * SUBPHASES;
  localparam int FLAG_W     = GROUPS * SUBPHASES;
  localparam int CNT_W      = 4;
  localparam logic [SUB_IDX_W-1:0] SUB_LAST = 2'h3;
  localparam logic [SUB_IDX_W-1:0] SUB_FIRST = 2'h0;

  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_WAIT = 2'b01,
    DRV_BUSY = 2'b10
  } drv_state_t;
endpackage : sysbus_pkg

// >>> verif/sysbus_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sysbus_checker
  import sysbus_pkg::*;
(
  // link domain
  input wire logic              link_clk,
  input wire logic              link_resetn_i,
  // resolved bus
  input wire logic [DATA_W-1:0] data_n,
  input wire logic [GROUPS-1:0] group_invert_flag_n,
  input wire logic [GROUPS-1:0] data_strobe_neg_n,
  input wire logic              data_bus_busy_n,
  input wire logic              data_valid_n,
  // per-end drives
  input wire logic              cpu_busy_o,
  input wire logic              cpu_valid_o,
  input wire logic              cpu_oe_n,
  input wire logic              agt_busy_o,
  input wire logic              agt_oe_n
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_resetn_i);

  // a sent group shows at most 8 asserted lines, under 8 once inverted
  function automatic bit groups_ok(logic [DATA_W-1:0] d, logic [GROUPS-1:0] f);
    bit ok;
    ok = 1'b1;
    for (int g = 0; g < GROUPS; g++) begin
      if ($countones(~d[g*GROUP_W +: GROUP_W]) > (f[g] ? HALF_GROUP : HALF_GROUP - 1))
        ok = 1'b0;
    end
    return ok;
  endfunction : groups_ok

  a_valid_busy: assert property (!data_valid_n |-> !data_bus_busy_n)
    else $error("valid without busy");
  a_owner_busy: assert property ((!cpu_oe_n |-> !cpu_busy_o) and (!agt_oe_n |-> !agt_busy_o))
    else $error("driver without busy");
  a_cpu_waits: assert property ($fell(cpu_busy_o) |-> $past(data_bus_busy_n))
    else $error("cpu took a busy bus");
  a_agt_waits: assert property ($fell(agt_busy_o) |-> $past(data_bus_busy_n))
    else $error("agent took a busy bus");
  a_single_owner: assert property (cpu_oe_n || agt_oe_n)
    else $error("two drivers on data");
  a_valid_owner: assert property (!data_valid_n |-> (!cpu_oe_n || !agt_oe_n))
    else $error("valid with no driver");
  a_strobe_valid: assert property (!data_valid_n |-> data_strobe_neg_n == 4'h0)
    else $error("strobes missing on valid clock");
  a_cpu_invert: assert property ((!cpu_oe_n && !cpu_valid_o) |-> groups_ok(data_n, group_invert_flag_n))
    else $error("group inversion wrong");
  a_agt_noinv: assert property ((!agt_oe_n && !data_valid_n) |-> group_invert_flag_n == 4'hf)
    else $error("agent inverted a group");
endmodule : sysbus_checker
`default_nettype wire

// >>> verif/system_bus_data_phase_handshake_tb.sv
`timescale 1ns/1ps
`default_nettype none
module system_bus_data_phase_handshake_tb;
  import sysbus_pkg::*;
  logic clk_i = 0, link_clk = 0, resetn = 0, link_resetn = 0;
  logic c_req = 0, c_last = 0, c_ack, c_rv, c_out_of_order_completion_n;
  logic [BEAT_W-1:0] c_data = '0, c_rd;
  logic a_req = 0, a_last = 0, a_out_of_order_completion_n = 0, a_ack, a_rv;
  logic [DATA_W-1:0] a_data = '0, a_rd;
  int n_errors = 0, checks_done = 0;

  sysbus_if sysbus_if_i (.link_clk(link_clk));
  sysbus_cpu_end sysbus_cpu_end_i (.clk_i(clk_i), .resetn_i(resetn), .send_req_i(c_req),
    .send_data_i(c_data), .send_last_i(c_last), .send_ack_o(c_ack), .recv_valid_o(c_rv),
    .recv_data_o(c_rd), .out_of_order_completion_n_seen_o(c_out_of_order_completion_n), .link_clk_i(link_clk),
    .link_resetn_i(link_resetn), .bus(sysbus_if_i));
  sysbus_agent_end sysbus_agent_end_i (.link_clk_i(link_clk), .link_resetn_i(link_resetn),
    .send_req_i(a_req), .send_data_i(a_data), .send_last_i(a_last), .out_of_order_completion_n_i(a_out_of_order_completion_n),
    .send_ack_o(a_ack), .recv_valid_o(a_rv), .recv_data_o(a_rd), .bus(sysbus_if_i));
  sysbus_checker sysbus_checker_i (.link_clk(link_clk), .link_resetn_i(link_resetn),
    .data_n(sysbus_if_i.data_n), .group_invert_flag_n(sysbus_if_i.group_invert_flag_n),
    .data_strobe_neg_n(sysbus_if_i.data_strobe_neg_n),
    .data_bus_busy_n(sysbus_if_i.data_bus_busy_n), .data_valid_n(sysbus_if_i.data_valid_n),
    .cpu_busy_o(sysbus_if_i.cpu_busy_o), .cpu_valid_o(sysbus_if_i.cpu_valid_o),
    .cpu_oe_n(sysbus_if_i.cpu_oe_n), .agt_busy_o(sysbus_if_i.agt_busy_o),
    .agt_oe_n(sysbus_if_i.agt_oe_n));

  // core clock 25 ns, link clock 160 ns with an odd phase offset
  initial forever #12.5 clk_i = ~clk_i;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(string what, logic [BEAT_W-1:0] seen, logic [BEAT_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ack is read where it has settled, before the edge that takes the beat;
  // the request drops just after that edge, so no beat is taken twice
  task automatic cpu_send(logic [DATA_W-1:0] w, logic last);
    logic taken;
    taken = 1'b0;
    @(posedge clk_i); #1;
    c_req = 1; c_data = {SUBPHASES{w}}; c_last = last;
    for (int n = 0; n < 200 && !taken; n++) begin
      @(negedge clk_i);
      taken = c_ack;
      @(posedge clk_i);
    end
    check("cpu ack", BEAT_W'(taken), 1);
    #1;
    c_req = 0;
  endtask : cpu_send

  task automatic agent_send(logic [DATA_W-1:0] w, logic last);
    logic taken;
    taken = 1'b0;
    @(posedge link_clk); #1;
    a_req = 1; a_data = w; a_last = last;
    for (int n = 0; n < 50 && !taken; n++) begin
      @(negedge link_clk);
      taken = a_ack;
      @(posedge link_clk);
    end
    check("agent ack", BEAT_W'(taken), 1);
    #1;
    a_req = 0;
  endtask : agent_send

  // receive pulses last a full cycle, so the falling edge sees them safely
  task automatic agent_expect(logic [DATA_W-1:0] w);
    for (int n = 0; n < 60 && !a_rv; n++) @(negedge link_clk);
    check("agent recv valid", BEAT_W'(a_rv), 1);
    check("agent recv data", BEAT_W'(a_rd), BEAT_W'(w));
    @(negedge link_clk);
  endtask : agent_expect

  task automatic cpu_expect(logic [DATA_W-1:0] w);
    for (int n = 0; n < 400 && !c_rv; n++) @(negedge clk_i);
    check("cpu recv valid", BEAT_W'(c_rv), 1);
    check("cpu recv data", c_rd, {SUBPHASES{w}});
    @(negedge clk_i);
  endtask : cpu_expect

  task automatic out_of_order_completion_n_expect(logic v);
    @(posedge link_clk); #1;
    a_out_of_order_completion_n = v;
    for (int n = 0; n < 100 && c_out_of_order_completion_n !== v; n++) @(negedge clk_i);
    check("out_of_order_completion_n seen", BEAT_W'(c_out_of_order_completion_n), BEAT_W'(v));
  endtask : out_of_order_completion_n_expect

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // watchdog: the whole sequence needs a few microseconds
  initial begin
    #100us;
    n_errors++;
    end_sim();
  end

  // main sequence: both directions back to back, then the out_of_order_completion_n path
  initial begin
    repeat (3) @(posedge clk_i);
    #1 resetn = 1;
    repeat (3) @(posedge link_clk);
    #1 link_resetn = 1;
    fork
      begin cpu_send(64'hffff_0f0f_0000_fffe, 0); cpu_send(64'h1234_5678_9abc_def0, 1); end
      begin agent_expect(64'hffff_0f0f_0000_fffe); agent_expect(64'h1234_5678_9abc_def0); end
    join
    $display("test cpu_to_agent done");
    fork
      begin agent_send(64'h00ff_00ff_a5a5_5a5a, 0); agent_send(64'hffff_ffff_ffff_ffff, 1); end
      begin cpu_expect(64'h00ff_00ff_a5a5_5a5a); cpu_expect(64'hffff_ffff_ffff_ffff); end
    join
    $display("test agent_to_cpu done");
    out_of_order_completion_n_expect(1);
    out_of_order_completion_n_expect(0);
    $display("test out_of_order_completion_n done");
    end_sim();
  end
endmodule : system_bus_data_phase_handshake_tb
`default_nettype wire
